// ---- pkg/lbrec_pkg.sv ----
// Constants and types shared by the last branch recorder
package lbrec_pkg;

  // Model register indices (port selects, not byte addresses)
  localparam logic [2:0] IDX_DEBUG_CONTROL  = 3'h0;
  localparam logic [2:0] IDX_BRANCH_SOURCE  = 3'h1;
  localparam logic [2:0] IDX_BRANCH_TARGET  = 3'h2;
  localparam logic [2:0] IDX_PRE_EXC_SOURCE = 3'h3;
  localparam logic [2:0] IDX_PRE_EXC_TARGET = 3'h4;

  // Debug control field positions
  localparam int BIT_RECORD_ENABLE = 0;
  localparam int BIT_STEP_ON_XFER  = 1;
  localparam int BIT_PIN_SEL_LO    = 2;
  localparam int BIT_TRACE_ENABLE  = 6;
  localparam int CTL_BITS          = 7;
  localparam int NUM_PINS          = 4;
  localparam int PTR_W             = 32;

  // Reset values
  localparam logic [CTL_BITS-1:0] CTL_RESET = 7'h00;
  localparam logic [PTR_W-1:0]    PTR_RESET = 32'h0000_0000;
  localparam logic [PTR_W-1:0]    RD_ZERO   = 32'h0000_0000;

  // Privilege level allowed to write the control register
  localparam logic [1:0] PRIV_KERNEL = 2'h0;

  // Kinds of control transfer reported by the core
  typedef enum logic [0:0] {
    XFER_BRANCH = 1'b0,
    XFER_INT_EXC = 1'b1
  } lbrec_xfer_t;

endpackage : lbrec_pkg

// ---- verilog/lbrec_top.sv ----
// Last branch recorder: control register, pointer capture, pins, trace
`timescale 1ns/1ps

// Function
// [R1] With recording enabled, capture source and target of latest transfers.
// [R2] Any debug exception clears the recording enable, freezing the pointers.
// [R3] Step-on-transfer makes the single-step flag trap only on transfers.
// [R4] A set pin select routes matches of its breakpoint address to its pin.
// [R5] Each reported breakpoint match pulses its pin active then inactive; a match while the pin is low gives no pulse.
// [R6] A clear pin select routes performance events; execution is unaffected.
// [R7] Trace enable emits a trace message for every branch, interrupt, exception; a transfer coinciding with a debug exception gives none.
// [R8] While trace messages are enabled the four pointers are undefined.
// [R9] Control writes accepted only at privilege zero or real-address mode.
// [R10] A taken branch loads its address as source, its destination as target.
// [R11] An interrupt or exception loads interrupted address and handler address.
// [R12] Interrupts and exceptions first copy branch pointers to pre-exception pair.
// [R13] Debug exceptions themselves are never recorded as transfers.
// [R14] Each of the four pointer registers is 32 bits, one pointer.
// [R15] Pointers are code segment offsets, not linear addresses.
// [R16] All four pointer registers are readable through the register read.
// [R17] Handler software must set recording enable again before resuming.
// [R18] Debug control resets to zero, everything disabled.
module lbrec_top
  import lbrec_pkg::*;
(
  input  wire logic                     mclk_i,
  input  wire logic                     rstn_i,
  // Model register access from the core
  input  wire logic                     reg_read_i,
  input  wire logic                     reg_write_i,
  input  wire logic [2:0]               reg_index_i,
  input  wire logic [31:0]              reg_wdata_i,
  input  wire logic [1:0]               priv_level_i,
  input  wire logic                     real_mode_i,
  output logic      [31:0]              reg_rdata_o,
  output logic                          reg_rvalid_o,
  output logic                          reg_fault_o,
  // Control transfers from the core
  input  wire logic                     xfer_valid_i,
  input  wire lbrec_pkg::lbrec_xfer_t   xfer_kind_i,
  input  wire logic [lbrec_pkg::PTR_W-1:0] xfer_from_i,
  input  wire logic [lbrec_pkg::PTR_W-1:0] xfer_to_i,
  input  wire logic                     debug_exception_i,
  input  wire logic                     instr_retire_i,
  input  wire logic                     single_step_flag_i,
  output logic                          step_trap_o,
  // Breakpoint and performance event sources, pins
  input  wire logic [lbrec_pkg::NUM_PINS-1:0] bp_match_i,
  input  wire logic [lbrec_pkg::NUM_PINS-1:0] perf_event_i,
  output logic      [lbrec_pkg::NUM_PINS-1:0] breakpoint_pin_n_o,
  // Branch trace message output
  output logic                          trace_valid_o,
  output lbrec_pkg::lbrec_xfer_t        trace_kind_o,
  output logic [lbrec_pkg::PTR_W-1:0]   trace_from_o,
  output logic [lbrec_pkg::PTR_W-1:0]   trace_to_o
);
  import lbrec_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [CTL_BITS-1:0] ctl_ff;
  logic [CTL_BITS-1:0] nxt_ctl;
  logic [PTR_W-1:0]    src_ff;
  logic [PTR_W-1:0]    tgt_ff;
  logic [PTR_W-1:0]    pre_src_ff;
  logic [PTR_W-1:0]    pre_tgt_ff;
  logic [31:0]         rdata_ff;
  logic                rvalid_ff;
  logic                fault_ff;
  logic                trap_ff;
  logic                tvalid_ff;
  lbrec_xfer_t         tkind_ff;
  logic [PTR_W-1:0]    tfrom_ff;
  logic [PTR_W-1:0]    tto_ff;
  logic [NUM_PINS-1:0] pin_n_ff;

  logic                rec_en;
  logic                step_xfer;
  logic                trace_en;
  logic [NUM_PINS-1:0] pin_sel;
  logic                priv_ok;
  logic                ctl_wr_ok;
  logic                wr_refused;
  logic                live_xfer;
  logic                rec_xfer;

  ////////////////////////////////////////////////////////////////////////
  // Field views

  // Control register fields
  assign rec_en    = ctl_ff[BIT_RECORD_ENABLE];
  assign step_xfer = ctl_ff[BIT_STEP_ON_XFER];
  assign trace_en  = ctl_ff[BIT_TRACE_ENABLE];
  assign pin_sel   = ctl_ff[BIT_PIN_SEL_LO +: NUM_PINS];

  // Privilege gate for control writes
  assign priv_ok    = (priv_level_i == PRIV_KERNEL) || real_mode_i; // [R9]
  assign ctl_wr_ok  = reg_write_i && (reg_index_i == IDX_DEBUG_CONTROL)
                      && priv_ok; // [R9]
  assign wr_refused = reg_write_i && !ctl_wr_ok;

  // A transfer that coincides with a debug exception is that exception
  assign live_xfer = xfer_valid_i && !debug_exception_i; // [R13]
  assign rec_xfer  = live_xfer && rec_en; // [R1] [R8]

  ////////////////////////////////////////////////////////////////////////
  // Debug control register

  // Next value: software write, then hardware clear on a debug exception
  always_comb
  begin
    nxt_ctl = ctl_ff;
    if (ctl_wr_ok)
    begin
      nxt_ctl = reg_wdata_i[CTL_BITS-1:0];
    end
    if (debug_exception_i)
    begin
      nxt_ctl[BIT_RECORD_ENABLE] = 1'b0; // [R2]
      nxt_ctl[BIT_STEP_ON_XFER]  = 1'b0;
    end
  end

  // Control register storage
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctl_ff <= CTL_RESET; // [R18]
    end
    else
    begin
      ctl_ff <= nxt_ctl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointer capture (code segment offsets as given by the core)

  // Branch source and target pair
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      src_ff <= PTR_RESET;
      tgt_ff <= PTR_RESET;
    end
    else if (rec_xfer)
    begin
      src_ff <= xfer_from_i; // [R10] [R11] [R15]
      tgt_ff <= xfer_to_i;   // [R10] [R11] [R14]
    end
  end

  // Pre-exception pair takes the old branch pair first
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pre_src_ff <= PTR_RESET;
      pre_tgt_ff <= PTR_RESET;
    end
    else if (rec_xfer && (xfer_kind_i == XFER_INT_EXC))
    begin
      pre_src_ff <= src_ff; // [R12]
      pre_tgt_ff <= tgt_ff; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read and write answers

  // Read data one cycle after the read strobe
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_ff  <= RD_ZERO;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_read_i;
      if (reg_read_i)
      begin
        if (reg_index_i == IDX_DEBUG_CONTROL)
        begin
          rdata_ff <= {{(32-CTL_BITS){1'b0}}, ctl_ff};
        end
        else if (reg_index_i == IDX_BRANCH_SOURCE)
        begin
          rdata_ff <= src_ff; // [R16]
        end
        else if (reg_index_i == IDX_BRANCH_TARGET)
        begin
          rdata_ff <= tgt_ff; // [R16]
        end
        else if (reg_index_i == IDX_PRE_EXC_SOURCE)
        begin
          rdata_ff <= pre_src_ff; // [R16]
        end
        else if (reg_index_i == IDX_PRE_EXC_TARGET)
        begin
          rdata_ff <= pre_tgt_ff; // [R16]
        end
        else
        begin
          rdata_ff <= RD_ZERO;
        end
      end
    end
  end

  // Refused write: wrong privilege, read-only or unmapped index
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fault_ff <= 1'b0;
    end
    else
    begin
      fault_ff <= wr_refused; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Single-step trap request

  // Trap on transfers only when step-on-transfer is set
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      trap_ff <= 1'b0;
    end
    else if (step_xfer)
    begin
      trap_ff <= single_step_flag_i && live_xfer; // [R3]
    end
    else
    begin
      trap_ff <= single_step_flag_i && instr_retire_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Branch trace messages

  // One message per transfer while trace is enabled
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tvalid_ff <= 1'b0;
      tkind_ff  <= XFER_BRANCH;
      tfrom_ff  <= PTR_RESET;
      tto_ff    <= PTR_RESET;
    end
    else
    begin
      tvalid_ff <= trace_en && live_xfer; // [R7]
      if (trace_en && live_xfer)
      begin
        tkind_ff <= xfer_kind_i;
        tfrom_ff <= xfer_from_i;
        tto_ff   <= xfer_to_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Breakpoint / performance pins (active low)

  // A source event while its pin is high pulses the pin low for one cycle
  for (genvar gi = 0; gi < NUM_PINS; gi++)
  begin : g_pin
    logic hit;
    // Select picks breakpoint matches or performance events
    assign hit = pin_sel[gi] ? bp_match_i[gi] : perf_event_i[gi]; // [R4] [R6]

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
      if (!rstn_i)
      begin
        pin_n_ff[gi] <= 1'b1;
      end
      else
      begin
        pin_n_ff[gi] <= !(hit && pin_n_ff[gi]); // [R5]
      end
    end

    a_pin_bp_match: assert property ( // [R4]
      @(posedge mclk_i) disable iff (!rstn_i)
      pin_sel[gi] && bp_match_i[gi] && pin_n_ff[gi] |=> !pin_n_ff[gi])
      else $error("breakpoint match not reported on pin");

    a_pin_perf_event: assert property ( // [R6]
      @(posedge mclk_i) disable iff (!rstn_i)
      !pin_sel[gi] && perf_event_i[gi] && pin_n_ff[gi] |=> !pin_n_ff[gi])
      else $error("performance event not reported on pin");

    a_pin_returns_high: assert property ( // [R5]
      @(posedge mclk_i) disable iff (!rstn_i)
      !pin_n_ff[gi] |=> pin_n_ff[gi])
      else $error("pin held active longer than one cycle");
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_o        = rdata_ff;
  assign reg_rvalid_o       = rvalid_ff;
  assign reg_fault_o        = fault_ff;
  assign step_trap_o        = trap_ff;
  assign trace_valid_o      = tvalid_ff;
  assign trace_kind_o       = tkind_ff;
  assign trace_from_o       = tfrom_ff;
  assign trace_to_o         = tto_ff;
  assign breakpoint_pin_n_o = pin_n_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_dbg_clears_enable: assert property ( // [R2]
    @(posedge mclk_i) disable iff (!rstn_i)
    debug_exception_i |=> !ctl_ff[BIT_RECORD_ENABLE])
    else $error("debug exception left recording enabled");
  a_dbg_not_recorded: assert property ( // [R13]
    @(posedge mclk_i) disable iff (!rstn_i)
    debug_exception_i |=> $stable(src_ff) && $stable(tgt_ff))
    else $error("debug exception changed captured pointers");
  a_idle_holds_ptrs: assert property ( // [R1]
    @(posedge mclk_i) disable iff (!rstn_i)
    !ctl_ff[BIT_RECORD_ENABLE] |=> $stable(src_ff) && $stable(pre_src_ff))
    else $error("pointers changed while recording disabled");
  a_branch_capture: assert property ( // [R10]
    @(posedge mclk_i) disable iff (!rstn_i)
    rec_xfer && xfer_kind_i == XFER_BRANCH |=>
      src_ff == $past(xfer_from_i) && tgt_ff == $past(xfer_to_i)
      && $stable(pre_tgt_ff))
    else $error("branch not captured into branch pair");
  a_exc_copy_first: assert property ( // [R11] [R12]
    @(posedge mclk_i) disable iff (!rstn_i)
    rec_xfer && xfer_kind_i == XFER_INT_EXC |=>
      pre_src_ff == $past(src_ff) && pre_tgt_ff == $past(tgt_ff)
      && tgt_ff == $past(xfer_to_i))
    else $error("exception did not copy then record");
  a_write_priv_gate: assert property ( // [R9]
    @(posedge mclk_i) disable iff (!rstn_i)
    reg_write_i && priv_level_i != PRIV_KERNEL && !real_mode_i
      |=> reg_fault_o && $stable(ctl_ff[BIT_TRACE_ENABLE]))
    else $error("unprivileged control write accepted");
  a_trace_emits: assert property ( // [R7]
    @(posedge mclk_i) disable iff (!rstn_i)
    trace_en && live_xfer |=> trace_valid_o && trace_to_o == $past(xfer_to_i))
    else $error("transfer with trace enabled gave no message");
  a_step_on_xfer: assert property ( // [R3]
    @(posedge mclk_i) disable iff (!rstn_i)
    step_xfer && single_step_flag_i && !live_xfer |=> !step_trap_o)
    else $error("step trap outside a transfer in transfer mode");
  a_read_source: assert property ( // [R16]
    @(posedge mclk_i) disable iff (!rstn_i)
    reg_read_i && reg_index_i == IDX_PRE_EXC_SOURCE
      |=> reg_rvalid_o && reg_rdata_o == $past(pre_src_ff))
    else $error("pre-exception source read wrong");

endmodule : lbrec_top

// ---- tb/lbrec_core_model.sv ----
// Execution core model reporting control transfers and breakpoint events
`timescale 1ns/1ps
module lbrec_core_model
  import lbrec_pkg::*;
(
  input  wire logic                         mclk_i,
  output logic                              xfer_valid_o,
  output lbrec_pkg::lbrec_xfer_t            xfer_kind_o,
  output logic [lbrec_pkg::PTR_W-1:0]       xfer_from_o,
  output logic [lbrec_pkg::PTR_W-1:0]       xfer_to_o,
  output logic                              debug_exception_o,
  output logic                              instr_retire_o,
  output logic [lbrec_pkg::NUM_PINS-1:0]    bp_match_o,
  output logic [lbrec_pkg::NUM_PINS-1:0]    perf_event_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle values at time zero
  initial
  begin
    xfer_valid_o      = 1'b0;
    xfer_kind_o       = XFER_BRANCH;
    xfer_from_o       = 32'h0000_0000;
    xfer_to_o         = 32'h0000_0000;
    debug_exception_o = 1'b0;
    instr_retire_o    = 1'b0;
    bp_match_o        = 4'h0;
    perf_event_o      = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle core event, launched at a falling edge; addresses scramble afterwards
  task automatic core_op(input logic v, input lbrec_xfer_t k, input logic [31:0] f,
                         input logic [31:0] t, input logic dbg, input logic ret,
                         input logic [3:0] bp, input logic [3:0] pe);
    @(negedge mclk_i);
    xfer_valid_o      = v;
    xfer_kind_o       = k;
    xfer_from_o       = f;
    xfer_to_o         = t;
    debug_exception_o = dbg;
    instr_retire_o    = ret;
    bp_match_o        = bp;
    perf_event_o      = pe;
    @(negedge mclk_i);
    xfer_valid_o      = 1'b0;
    xfer_from_o       = ~f; // Stale addresses must not look valid
    xfer_to_o         = ~t;
    debug_exception_o = 1'b0;
    instr_retire_o    = 1'b0;
    bp_match_o        = 4'h0;
    perf_event_o      = 4'h0;
  endtask : core_op
endmodule : lbrec_core_model

// ---- tb/last_branch_recorder_test.sv ----
// Self-checking testbench of the last branch recorder
`timescale 1ns/1ps
module last_branch_recorder_test;
  import lbrec_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic reg_write_i = 1'b0;
  logic [2:0] reg_index_i = 3'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [1:0] priv_level_i = 2'h0;
  logic real_mode_i = 1'b0;
  logic single_step_flag_i = 1'b0;
  logic [31:0] reg_rdata_o, xfer_from_i, xfer_to_i, trace_from_o, trace_to_o;
  logic reg_rvalid_o, reg_fault_o, xfer_valid_i, debug_exception_i, instr_retire_i;
  logic step_trap_o, trace_valid_o;
  lbrec_xfer_t xfer_kind_i, trace_kind_o;
  logic [3:0] bp_match_i, perf_event_i, breakpoint_pin_n_o;
  int err_count = 0;
  int check_count = 0;

  always #2.5 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and core model
  lbrec_top i_lbrec_top (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_read_i(reg_read_i),
    .reg_write_i(reg_write_i), .reg_index_i(reg_index_i), .reg_wdata_i(reg_wdata_i),
    .priv_level_i(priv_level_i), .real_mode_i(real_mode_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .reg_fault_o(reg_fault_o), .xfer_valid_i(xfer_valid_i),
    .xfer_kind_i(xfer_kind_i), .xfer_from_i(xfer_from_i), .xfer_to_i(xfer_to_i),
    .debug_exception_i(debug_exception_i), .instr_retire_i(instr_retire_i),
    .single_step_flag_i(single_step_flag_i), .step_trap_o(step_trap_o),
    .bp_match_i(bp_match_i), .perf_event_i(perf_event_i),
    .breakpoint_pin_n_o(breakpoint_pin_n_o), .trace_valid_o(trace_valid_o),
    .trace_kind_o(trace_kind_o), .trace_from_o(trace_from_o), .trace_to_o(trace_to_o));
  lbrec_core_model i_lbrec_core_model (.mclk_i(mclk_i), .xfer_valid_o(xfer_valid_i),
    .xfer_kind_o(xfer_kind_i), .xfer_from_o(xfer_from_i), .xfer_to_o(xfer_to_i),
    .debug_exception_o(debug_exception_i), .instr_retire_o(instr_retire_i),
    .bp_match_o(bp_match_i), .perf_event_o(perf_event_i));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, register access and verdict tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic wr(input logic [2:0] idx, input logic [31:0] d, input logic [1:0] pl,
                    input logic rm, input logic flt);
    @(negedge mclk_i);
    reg_write_i = 1'b1;
    reg_index_i = idx;
    reg_wdata_i = d;
    priv_level_i = pl;
    real_mode_i = rm;
    @(negedge mclk_i);
    reg_write_i = 1'b0;
    chk(reg_fault_o, flt);
  endtask : wr

  task automatic rd(input logic [2:0] idx, input logic [31:0] exp);
    @(negedge mclk_i);
    reg_read_i = 1'b1;
    reg_index_i = idx;
    @(negedge mclk_i);
    reg_read_i = 1'b0;
    chk(reg_rvalid_o, 1'b1);
    chk(reg_rdata_o, exp);
  endtask : rd

  // Core event through the partner model
  task automatic xf(input logic v, input lbrec_xfer_t k, input logic [31:0] f,
                    input logic [31:0] t, input logic dbg, input logic ret,
                    input logic [3:0] bp, input logic [3:0] pe);
    i_lbrec_core_model.core_op(v, k, f, t, dbg, ret, bp, pe);
  endtask : xf

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    #100us;
    err_count++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (5) @(negedge mclk_i);
    rstn_i = 1'b1;
    rd(IDX_DEBUG_CONTROL, 32'h0);
    chk(breakpoint_pin_n_o, 4'hf);
    // Privilege gating of control writes and read-only pointers
    wr(IDX_DEBUG_CONTROL, 32'h01, 2'h3, 1'b0, 1'b1);
    rd(IDX_DEBUG_CONTROL, 32'h0);
    wr(IDX_DEBUG_CONTROL, 32'hffff_ff81, 2'h3, 1'b1, 1'b0);
    rd(IDX_DEBUG_CONTROL, 32'h01);
    wr(IDX_BRANCH_SOURCE, 32'h55, 2'h0, 1'b0, 1'b1);
    rd(IDX_BRANCH_SOURCE, 32'h0);
    rd(3'h5, 32'h0);
    // Branch then interrupt
    xf(1, XFER_BRANCH, 32'h1000_0010, 32'h2000_0020, 0, 0, 0, 0);
    chk(trace_valid_o, 1'b0);
    xf(1, XFER_INT_EXC, 32'h3000_0030, 32'hc000_00c0, 0, 0, 0, 0);
    rd(IDX_BRANCH_SOURCE, 32'h3000_0030);
    rd(IDX_BRANCH_TARGET, 32'hc000_00c0);
    rd(IDX_PRE_EXC_SOURCE, 32'h1000_0010);
    rd(IDX_PRE_EXC_TARGET, 32'h2000_0020);
    // Debug exception freezes pointers and is not recorded
    xf(1, XFER_BRANCH, 32'hdead_0001, 32'hdead_0002, 1, 0, 0, 0);
    rd(IDX_DEBUG_CONTROL, 32'h0);
    rd(IDX_BRANCH_SOURCE, 32'h3000_0030);
    xf(1, XFER_BRANCH, 32'h4000_0040, 32'h5000_0050, 0, 0, 0, 0);
    rd(IDX_BRANCH_SOURCE, 32'h3000_0030);
    rd(IDX_BRANCH_TARGET, 32'hc000_00c0);
    rd(IDX_PRE_EXC_SOURCE, 32'h1000_0010);
    wr(IDX_DEBUG_CONTROL, 32'h01, 2'h0, 1'b0, 1'b0);
    xf(1, XFER_BRANCH, 32'h6000_0060, 32'h7000_0070, 0, 0, 0, 0);
    rd(IDX_BRANCH_SOURCE, 32'h6000_0060);
    rd(IDX_BRANCH_TARGET, 32'h7000_0070);
    rd(IDX_PRE_EXC_TARGET, 32'h2000_0020);
    // Single-step on transfers versus every instruction
    single_step_flag_i = 1'b1;
    wr(IDX_DEBUG_CONTROL, 32'h02, 2'h0, 1'b0, 1'b0);
    xf(0, XFER_BRANCH, 32'h0, 32'h0, 0, 1, 0, 0);
    chk(step_trap_o, 1'b0);
    xf(1, XFER_BRANCH, 32'h8, 32'h9, 0, 0, 0, 0);
    chk(step_trap_o, 1'b1);
    wr(IDX_DEBUG_CONTROL, 32'h00, 2'h0, 1'b0, 1'b0);
    xf(0, XFER_BRANCH, 32'h0, 32'h0, 0, 1, 0, 0);
    chk(step_trap_o, 1'b1);
    single_step_flag_i = 1'b0;
    // Pins 0 and 1 report breakpoints, pins 2 and 3 performance events
    wr(IDX_DEBUG_CONTROL, 32'h0c, 2'h0, 1'b0, 1'b0);
    xf(0, XFER_BRANCH, 32'h0, 32'h0, 0, 0, 4'h5, 4'ha);
    chk(breakpoint_pin_n_o, 4'h6);
    @(negedge mclk_i);
    chk(breakpoint_pin_n_o, 4'hf);
    xf(0, XFER_BRANCH, 32'h0, 32'h0, 0, 0, 4'ha, 4'h5);
    chk(breakpoint_pin_n_o, 4'h9);
    // Trace messages
    wr(IDX_DEBUG_CONTROL, 32'h40, 2'h0, 1'b0, 1'b0);
    xf(1, XFER_INT_EXC, 32'h0abc_0001, 32'h0abc_0002, 0, 0, 0, 0);
    chk(trace_valid_o, 1'b1);
    chk(trace_kind_o, 32'h1);
    chk(trace_from_o, 32'h0abc_0001);
    chk(trace_to_o, 32'h0abc_0002);
    @(negedge mclk_i);
    chk(trace_valid_o, 1'b0);
    final_report();
  end
endmodule : last_branch_recorder_test
